// ==== hdl/gpt_pkg.sv ====
// Purpose: Shared constants and carriers for the toggle I/O port
// Assumes: Sixteen pins, one device clock
// Notes:   Reset values give all pins input with latches low
package gpt_pkg;

  localparam int               GPT_PINS       = 16;
  localparam int               GPT_IDX_W      = 4;
  localparam logic [15:0]      GPT_LATCH_RST  = 16'h0000;
  localparam logic [15:0]      GPT_DIR_RST    = 16'h0000;
  localparam logic [1:0]       GPT_OP_NONE    = 2'h0;
  localparam logic [1:0]       GPT_OP_TOGGLE  = 2'h1;
  localparam logic [1:0]       GPT_OP_COPY    = 2'h2;
  localparam logic [1:0]       GPT_OP_WRITE   = 2'h3;

  // One request from the interpreter logic
  typedef struct packed {
    logic                      valid;
    logic [1:0]                op;
    logic [GPT_IDX_W-1:0]      pin;
    logic                      latch_val;
    logic                      dir_val;
  } gpt_req_type;

  // Port state as seen by the interpreter
  typedef struct packed {
    logic [GPT_PINS-1:0]       output_latch_word;
    logic [GPT_PINS-1:0]       pin_direction_word;
    logic [GPT_PINS-1:0]       pin_sense_word;
  } gpt_state_type;

endpackage

// ==== hdl/gpt_sync.sv ====
// Purpose: Two-stage synchroniser for the sensed pin levels
// Assumes: Pin levels are asynchronous to sys_clk_i
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
module gpt_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             sys_clk_i,  // Device clock
  input  wire logic             resetn_i,   // Async reset, low
  input  wire logic [WIDTH-1:0] async_i,    // Raw pin levels
  output logic      [WIDTH-1:0] sync_o      // Synchronised levels
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  // Next values of both stages
  always_comb begin
    nxt_meta = async_i;
    nxt_sync = meta_ff;
  end

  // Register stages
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_o = sync_ff;

endmodule

// ==== hdl/gpt_port.sv ====
// Purpose: Sixteen-pin I/O port with per-pin toggle, copy and write
// Assumes: Requests come from interpreter logic on sys_clk_i
// Notes:   One request per cycle; result visible at next edge
`timescale 1ns/1ps
module gpt_port
  import gpt_pkg::*;
#(
  parameter int PINS = GPT_PINS
) (
  input  wire logic                sys_clk_i,       // Device clock
  input  wire logic                resetn_i,        // Async reset, low
  input  wire gpt_req_type         req_i,           // Port request
  input  wire logic [PINS-1:0]     pin_level_i,     // Pin levels in
  output logic      [PINS-1:0]     pin_drive_o,     // Pin output value
  output logic      [PINS-1:0]     pin_drive_en_o,  // Pin output enable
  output logic                     done_o,          // Request applied
  output gpt_state_type            state_o          // Port state
);

  logic [PINS-1:0] output_latch_word_ff;
  logic [PINS-1:0] pin_direction_word_ff;
  logic [PINS-1:0] nxt_output_latch_word;
  logic [PINS-1:0] nxt_pin_direction_word;
  logic            done_ff;
  logic            nxt_done;
  logic [PINS-1:0] pin_sense_word;
  gpt_state_type   state_ff;
  gpt_state_type   nxt_state;

  // Request strobes and per-pin words
  logic            is_toggle;
  logic            is_copy;
  logic            is_write;
  logic            is_taken;
  logic [PINS-1:0] sel_mask;
  logic [PINS-1:0] write_latch_word;
  logic [PINS-1:0] write_dir_word;

  // One-hot mask for a pin index
  function automatic logic [PINS-1:0] pin_mask(
    input logic [GPT_IDX_W-1:0] idx
  );
    logic [PINS-1:0] m;
    m      = '0;
    m[idx] = 1'b1;
    return m;
  endfunction

  // Replace the selected bits of a word, keep the others
  function automatic logic [PINS-1:0] merge_word(
    input logic [PINS-1:0] word,
    input logic [PINS-1:0] value,
    input logic [PINS-1:0] mask
  );
    return (word & ~mask) | (value & mask);
  endfunction

  // Invert the selected bits of a stored word
  function automatic logic [PINS-1:0] flip_word(
    input logic [PINS-1:0] word,
    input logic [PINS-1:0] mask
  );
    return word ^ mask;
  endfunction

  // Repeat one bit across every pin position
  function automatic logic [PINS-1:0] spread_bit(
    input logic b
  );
    return {PINS{b}};
  endfunction

  // Sensed levels pass two flip-flops. A copy therefore takes the
  // level seen two edges earlier; a pin whose direction just changed
  // needs two idle cycles before a copy sees its new level.
  gpt_sync #(
    .WIDTH (PINS)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .async_i   (pin_level_i),
    .sync_o    (pin_sense_word)
  );

  // Split the request into one strobe per operation; op none and an
  // idle cycle leave every strobe low, so nothing moves
  always_comb begin
    // One-hot mask of the named pin
    sel_mask  = pin_mask(req_i.pin);
    is_toggle = 1'b0;
    is_copy   = 1'b0;
    is_write  = 1'b0;
    if (req_i.valid) begin
      case (req_i.op)
        GPT_OP_TOGGLE: begin
          is_toggle = 1'b1;
        end
        GPT_OP_COPY: begin
          is_copy = 1'b1;
        end
        GPT_OP_WRITE: begin
          is_write = 1'b1;
        end
        default: begin
          // Op none: no change and no done pulse
          is_toggle = 1'b0;
        end
      endcase
    end
    // Only a real operation counts as taken
    is_taken = is_toggle | is_copy | is_write;
  end

  // Values a write places under the selected pin; the other pins
  // keep their latch and direction bits
  always_comb begin
    write_latch_word = spread_bit(req_i.latch_val);
    write_dir_word   = spread_bit(req_i.dir_val);
  end

  // Next latch word. A toggle flips the stored latch, never the sensed
  // level: an input pulled high with its latch low starts driving high
  // and its level stays put. A copy before the toggle avoids that.
  always_comb begin
    nxt_output_latch_word = output_latch_word_ff;
    if (is_toggle) begin
      nxt_output_latch_word = flip_word(output_latch_word_ff,
                                        sel_mask);
    end else if (is_copy) begin
      // Synced level of the pin copied into its latch
      nxt_output_latch_word = merge_word(output_latch_word_ff,
                                         pin_sense_word,
                                         sel_mask);
    end else if (is_write) begin
      // Latch bit set as the write asks
      nxt_output_latch_word = merge_word(output_latch_word_ff,
                                         write_latch_word,
                                         sel_mask);
    end
  end

  // Output latch register; it is the drive value, which reaches the
  // pin only while the direction bit is set
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      output_latch_word_ff <= PINS'(GPT_LATCH_RST);
    end else begin
      output_latch_word_ff <= nxt_output_latch_word;
    end
  end

  // Next direction word; a toggle makes the pin an output whatever it
  // was, a write sets the direction bit as asked
  always_comb begin
    nxt_pin_direction_word = pin_direction_word_ff;
    if (is_toggle) begin
      // Toggled pin always ends up an output
      nxt_pin_direction_word = pin_direction_word_ff | sel_mask;
    end else if (is_write) begin
      // Direction bit set as the write asks
      nxt_pin_direction_word = merge_word(pin_direction_word_ff,
                                          write_dir_word,
                                          sel_mask);
    end
  end

  // Direction register; same edge and same toggle and write strobes as the
  // latch, so no toggle or write shows one bit updated without the other
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_direction_word_ff <= PINS'(GPT_DIR_RST);
    end else begin
      pin_direction_word_ff <= nxt_pin_direction_word;
    end
  end

  // Done pulse for every applied request; op none and idle cycles
  // give none, so the interpreter can count completed requests
  always_comb begin
    nxt_done = is_taken;
  end

  // Done register; high for exactly one cycle per applied request
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= nxt_done;
    end
  end

  // Snapshot of port state for the interpreter; the sense field lags
  // the synchroniser by one more edge
  always_comb begin
    nxt_state.output_latch_word  = nxt_output_latch_word;
    nxt_state.pin_direction_word = nxt_pin_direction_word;
    nxt_state.pin_sense_word     = pin_sense_word;
  end

  // Snapshot register; its latch and direction fields match the
  // port outputs after the same edge
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs straight from flip-flops; the enable is high while the
  // port drives a pin, so an input pin is left to its pull resistor
  assign pin_drive_o    = output_latch_word_ff;
  assign pin_drive_en_o = pin_direction_word_ff;
  assign done_o         = done_ff;
  assign state_o        = state_ff;

endmodule

// ==== verification/gpt_port_asserts.sv ====
// Purpose: Checks on the toggle port
// Assumes: One clock
// Notes:   Bound to gpt_port
`timescale 1ns/1ps
module gpt_port_asserts
  import gpt_pkg::*;
(
  input wire logic          sys_clk_i,      // Clock
  input wire logic          resetn_i,       // Reset
  input wire gpt_req_type   req_i,          // Request
  input wire logic [15:0]   pin_drive_o,    // Latch
  input wire logic [15:0]   pin_drive_en_o, // Direction
  input wire logic          done_o,         // Done
  input wire gpt_state_type state_o         // State
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // Request kinds
  sequence s_tgl; req_i.valid && req_i.op == GPT_OP_TOGGLE; endsequence
  sequence s_cpy; req_i.valid && req_i.op == GPT_OP_COPY; endsequence
  AST_LATCH: assert property (s_tgl |=>
    pin_drive_o == ($past(pin_drive_o) ^
    (16'h0001 << $past(req_i.pin)))) else $error("latch");
  AST_DIR: assert property (s_tgl |=>
    pin_drive_en_o == ($past(pin_drive_en_o) |
    (16'h0001 << $past(req_i.pin)))) else $error("dir");
  AST_OUT: assert property (s_tgl ##0 pin_drive_en_o[req_i.pin]
    |=> $stable(pin_drive_en_o) && done_o) else $error("out");
  AST_COPY: assert property (s_cpy |=>
    pin_drive_o[$past(req_i.pin)] ==
    state_o.pin_sense_word[$past(req_i.pin)]) else $error("copy");
  AST_SAME: assert property (s_tgl |=> done_o &&
    pin_drive_en_o[$past(req_i.pin)] &&
    pin_drive_o[$past(req_i.pin)] != $past(pin_drive_o[req_i.pin]) &&
    state_o.output_latch_word == pin_drive_o &&
    state_o.pin_direction_word == pin_drive_en_o) else $error("same");
  AST_IDLE: assert property (!req_i.valid |=> !done_o &&
    $stable(pin_drive_o)) else $error("idle");
endmodule
bind gpt_port gpt_port_asserts i_gpt_port_asserts (.sys_clk_i(sys_clk_i),
  .resetn_i(resetn_i), .req_i(req_i), .pin_drive_o(pin_drive_o),
  .pin_drive_en_o(pin_drive_en_o), .done_o(done_o), .state_o(state_o));

// ==== verification/gpt_pins_model.sv ====
// Purpose: Pull-ups on the port pins
// Assumes: Every pin pulled high
// Notes:   A driven pin shows its latch
`timescale 1ns/1ps
module gpt_pins_model (
  input  wire logic [15:0] drive_i, // Latch word
  input  wire logic [15:0] en_i,    // Enables
  output logic      [15:0] level_o  // Wire levels
);
  // Undriven pins float high
  assign level_o = (drive_i & en_i) | ~en_i;
endmodule

// ==== verification/tb_top.sv ====
// Purpose: Bench for the toggle port
// Assumes: Pull-ups on all pins
// Notes:   One task per scenario
`timescale 1ns/1ps
module tb_top;
  import gpt_pkg::*;
  logic          sys_clk_i = 1'b0;
  logic          resetn_i = 1'b0;
  gpt_req_type   req_i = '0;
  logic [15:0]   lvl, drv, en;
  logic          done;
  gpt_state_type st;
  int            fails = 0;
  int            checks_done = 0;
  // 10 MHz clock
  always #50 sys_clk_i = ~sys_clk_i;
  gpt_port i_gpt_port (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .req_i(req_i), .pin_level_i(lvl), .pin_drive_o(drv),
    .pin_drive_en_o(en), .done_o(done), .state_o(st));
  gpt_pins_model i_gpt_pins_model (.drive_i(drv), .en_i(en), .level_o(lvl));
  task chk(input string n, input logic [15:0] s, e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  // One request, judged after the taking edge
  task req(input logic [1:0] op, input logic [3:0] p,
           input logic lv = 1'b0, input logic dv = 1'b0);
    @(posedge sys_clk_i);
    req_i <= '{1'b1, op, p, lv, dv};
    @(posedge sys_clk_i);
    req_i <= '0;
    #1 chk("done", 16'(done), 16'(op != GPT_OP_NONE));
  endtask
  // Reset held for some edges, then released; port cleared
  task t_reset(input int hold);
    resetn_i <= 1'b0;
    repeat (hold - 1) @(posedge sys_clk_i);
    #1 chk("rst drive", drv, 16'h0000);
    chk("rst en", en, 16'h0000);
    chk("rst done", 16'(done), 16'h0000);
    @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1 chk("st sense", st.pin_sense_word, 16'hffff);
    chk("st latch", st.output_latch_word, 16'h0000);
    chk("st dir", st.pin_direction_word, 16'h0000);
  endtask
  // Pulled-up input pin keeps its level
  task t_pullup;
    req(GPT_OP_TOGGLE, 4'h2);
    chk("drive", drv, 16'h0004);
    chk("en", en, 16'h0004);
    chk("level", lvl, 16'hffff);
    chk("st latch", st.output_latch_word, 16'h0004);
    chk("st dir", st.pin_direction_word, 16'h0004);
  endtask
  // Toggle on an output pin
  task t_output;
    req(GPT_OP_TOGGLE, 4'h2);
    chk("drive", drv, 16'h0000);
    chk("en", en, 16'h0004);
  endtask
  // Copy the sensed level, then the pin flips
  task t_copy;
    req(GPT_OP_COPY, 4'hf);
    chk("drive", drv, 16'h8000);
    req(GPT_OP_TOGGLE, 4'hf);
    chk("level", lvl, 16'h7ffb);
  endtask
  // Every pin index in turn, with an idle cycle after each request
  task t_all;
    for (int i = 0; i < 16; i++) req(GPT_OP_TOGGLE, 4'(i));
    chk("drive", drv, 16'hffff);
    chk("en", en, 16'hffff);
  endtask
  // Write sets latch and direction; op none changes nothing
  task t_write;
    req(GPT_OP_WRITE, 4'h9, 1'b1, 1'b1);
    chk("drive", drv, 16'h0200);
    chk("en", en, 16'h8204);
    req(GPT_OP_WRITE, 4'h9, 1'b0, 1'b0);
    chk("drive", drv, 16'h0000);
    chk("en", en, 16'h8004);
    req(GPT_OP_NONE, 4'h9, 1'b1, 1'b1);
    chk("drive", drv, 16'h0000);
    chk("en", en, 16'h8004);
  endtask
  // Reset in mid-run clears the port; the next toggle still works
  task t_midrun;
    @(posedge sys_clk_i);
    t_reset(2);
    req(GPT_OP_TOGGLE, 4'h0);
    chk("drive", drv, 16'h0001);
    chk("en", en, 16'h0001);
  endtask
  task conclude;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Reset, then the scenarios
  initial begin
    t_reset(8);
    t_pullup;
    t_output;
    t_copy;
    t_write;
    t_all;
    t_midrun;
    conclude;
  end
endmodule
